// ---- design/pvic_pkg.sv ----
// Package: constants and types for the prioritized vector interrupt controller
package pvic_pkg;
    localparam int NUM_SRC = 25;
    localparam int LVL_W = 2;
    localparam int VEC_W = 16;
    localparam int IDX_W = 5;
    // Source indices in fixed vector order (index 0 wins ties)
    localparam logic [4:0] SRC_WDT = 5'h00;
    localparam logic [4:0] SRC_TMR2 = 5'h01;
    localparam logic [4:0] SRC_TMR1 = 5'h02;
    localparam logic [4:0] SRC_TMR0 = 5'h03;
    localparam logic [4:0] SRC_UART0_RX = 5'h04;
    localparam logic [4:0] SRC_UART0_TX = 5'h05;
    localparam logic [4:0] SRC_I2C = 5'h06;
    localparam logic [4:0] SRC_SPI = 5'h07;
    localparam logic [4:0] SRC_ADC = 5'h08;
    localparam logic [4:0] SRC_PIN_BASE = 5'h09;
    localparam logic [4:0] SRC_TMR3 = 5'h11;
    localparam logic [4:0] SRC_UART1_RX = 5'h12;
    localparam logic [4:0] SRC_UART1_TX = 5'h13;
    localparam logic [4:0] SRC_DMA = 5'h14;
    localparam logic [4:0] SRC_DUAL_BASE = 5'h15;
    // Vector addresses
    localparam logic [15:0] VEC_RESET = 16'h0002;
    localparam logic [15:0] VEC_WDT = 16'h0004;
    localparam logic [15:0] VEC_TRAP = 16'h0006;
    localparam logic [15:0] VEC_FIRST_SRC = 16'h0008;
    localparam logic [15:0] VEC_STEP = 16'h0002;
    // Levels
    localparam logic [1:0] LVL_OFF = 2'h0;
    localparam logic [1:0] LVL_TOP = 2'h3;
    // Sources held high by their peripheral (bit set = continuous)
    localparam logic [24:0] CONT_MASK = 25'h00c00f1;
    localparam logic [24:0] PEND_RESET = 25'h0000000;

    typedef struct packed {
        logic valid;
        logic [4:0] idx;
        logic [15:0] vector;
    } pvic_req_t;
endpackage : pvic_pkg

// ---- design/pvic_edge_det.sv ----
// Synchronised edge detector for one port pin
`timescale 1ns/1ps
module pvic_edge_det (
    // Clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // Pin and selection
    input wire logic pin,
    input wire logic both_edges,
    input wire logic falling,
    // Detected edge
    output logic hit
);
    logic sync1;
    logic sync2;
    logic sync3;

    // Third stage holds the previous synchronised value; a change counts as soon as it differs from the second
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            sync1 <= 1'b0;
            sync2 <= 1'b0;
            sync3 <= 1'b0;
        end else begin
            sync1 <= pin;
            sync2 <= sync1;
            sync3 <= sync2;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            hit <= 1'b0;
        end else begin
            if (both_edges) begin
                hit <= sync2 ^ sync3;
            end else if (falling) begin
                hit <= sync3 & ~sync2;
            end else begin
                hit <= sync2 & ~sync3;
            end
        end
    end
endmodule : pvic_edge_det

// ---- design/pvic_ctrl.sv ----
// Prioritized vector interrupt controller top
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
module pvic_ctrl #(
    parameter bit HAS_TMR3 = 1'b1
) (
    // Clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // Peripheral requests, same clock domain
    input wire logic wdt_irq,
    input wire logic wdt_irq_mode,
    input wire logic [2:0] tmr_irq,
    input wire logic tmr3_irq,
    input wire logic uart0_rx_irq,
    input wire logic uart0_tx_irq,
    input wire logic uart1_rx_irq,
    input wire logic uart1_tx_irq,
    input wire logic i2c_irq,
    input wire logic spi_irq,
    input wire logic adc_irq,
    input wire logic dma_irq,
    // Port pins, asynchronous
    input wire logic [7:0] port_a_pin,
    input wire logic [7:0] port_d_pin,
    input wire logic [3:0] port_c_pin,
    // Pin configuration
    input wire logic [7:0] pin_port_sel,
    input wire logic [7:0] pin_falling,
    // Software control
    input wire logic [24:0] enable,
    input wire logic [49:0] level,
    input wire logic gate_set,
    input wire logic gate_clear,
    input wire logic [24:0] pend_wr_zero,
    // Core side
    input wire logic trap_req,
    input wire logic ack,
    output logic global_irq_gate,
    output logic [24:0] pending,
    output pvic_pkg::pvic_req_t req,
    output logic [15:0] reset_vector,
    output logic [15:0] trap_vector
);
    ////////////////////////////////////////////////////////////////////////////
    logic [11:0] pin_raw;
    logic [11:0] pin_hit;
    logic [24:0] src;
    logic [24:0] next_pending;
    pvic_pkg::pvic_req_t next_req;

    // Shared pins: chosen port drives the edge detector
    // Synchronisers clear low, so a pin idling high in rising mode gives one false edge
    genvar g;
    generate
        for (g = 0; g < 8; g++) begin : g_pin
            assign pin_raw[g] = pin_port_sel[g] ? port_d_pin[g] : port_a_pin[g];
            pvic_edge_det u_det (
                .clk(clk),
                .arst_n(arst_n),
                .pin(pin_raw[g]),
                .both_edges(1'b0),
                .falling(pin_falling[g]),
                .hit(pin_hit[g])
            );
        end
        for (g = 0; g < 4; g++) begin : g_dual
            assign pin_raw[8 + g] = port_c_pin[g];
            pvic_edge_det u_det (
                .clk(clk),
                .arst_n(arst_n),
                .pin(pin_raw[8 + g]),
                .both_edges(1'b1),
                .falling(1'b0),
                .hit(pin_hit[8 + g])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // Source vector in fixed order, lowest index first
    always_comb begin
        src = '0;
        src[pvic_pkg::SRC_WDT] = wdt_irq & wdt_irq_mode;
        src[pvic_pkg::SRC_TMR2] = tmr_irq[2];
        src[pvic_pkg::SRC_TMR1] = tmr_irq[1];
        src[pvic_pkg::SRC_TMR0] = tmr_irq[0];
        src[pvic_pkg::SRC_UART0_RX] = uart0_rx_irq;
        src[pvic_pkg::SRC_UART0_TX] = uart0_tx_irq;
        src[pvic_pkg::SRC_I2C] = i2c_irq;
        src[pvic_pkg::SRC_SPI] = spi_irq;
        src[pvic_pkg::SRC_ADC] = adc_irq;
        for (int i = 0; i < 8; i++) begin
            src[int'(pvic_pkg::SRC_PIN_BASE) + i] = pin_hit[7 - i];
        end
        src[pvic_pkg::SRC_TMR3] = tmr3_irq & HAS_TMR3;
        src[pvic_pkg::SRC_UART1_RX] = uart1_rx_irq;
        src[pvic_pkg::SRC_UART1_TX] = uart1_tx_irq;
        src[pvic_pkg::SRC_DMA] = dma_irq;
        for (int i = 0; i < 4; i++) begin
            src[int'(pvic_pkg::SRC_DUAL_BASE) + i] = pin_hit[11 - i];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Pending bits; a new request wins over a clear in the same cycle
    // Hence a held source must go quiet before a zero write can clear it
    always_comb begin
        next_pending = pending;
        for (int i = 0; i < pvic_pkg::NUM_SRC; i++) begin
            if (pend_wr_zero[i]) begin
                next_pending[i] = 1'b0;
            end
            if (ack && req.valid && (int'(req.idx) == i) && !pvic_pkg::CONT_MASK[i]) begin
                next_pending[i] = 1'b0;
            end
            if (src[i]) begin
                next_pending[i] = 1'b1;
            end
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            pending <= pvic_pkg::PEND_RESET;
        end else begin
            pending <= next_pending;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Global gate: acknowledge and trap close it, as does reset
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            global_irq_gate <= 1'b0;
        end else if (gate_clear || (ack && req.valid) || trap_req) begin
            global_irq_gate <= 1'b0;
        end else if (gate_set) begin
            global_irq_gate <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Winner: highest level first, then lowest index
    // Strict compare keeps the lowest index on a tie
    always_comb begin
        logic [1:0] best_lvl;
        logic [1:0] lvl;
        lvl = pvic_pkg::LVL_OFF;
        best_lvl = pvic_pkg::LVL_OFF;
        next_req = '0;
        for (int i = 0; i < pvic_pkg::NUM_SRC; i++) begin
            lvl = level[2 * i +: 2];
            // Watchdog always at top level
            if (i == int'(pvic_pkg::SRC_WDT)) begin
                lvl = pvic_pkg::LVL_TOP;
            end
            if (pending[i] && enable[i] && lvl != pvic_pkg::LVL_OFF && lvl > best_lvl) begin
                best_lvl = lvl;
                next_req.valid = 1'b1;
                next_req.idx = 5'(i);
            end
        end
        // Watchdog at 0004h, trap slot at 0006h skipped, then 0008h onward
        if (next_req.idx == pvic_pkg::SRC_WDT) begin
            next_req.vector = pvic_pkg::VEC_WDT;
        end else begin
            next_req.vector = 16'(pvic_pkg::VEC_FIRST_SRC
                + pvic_pkg::VEC_STEP * 16'(next_req.idx - 5'h01));
        end
        if (!global_irq_gate) begin
            next_req.valid = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            req <= '0;
        end else if (ack && req.valid) begin
            // Drop for a cycle so the taken request is not offered twice
            req <= '0;
        end else begin
            req <= next_req;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Fixed vectors for the core's reset and trap entries
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            reset_vector <= pvic_pkg::VEC_RESET;
        end else begin
            reset_vector <= pvic_pkg::VEC_RESET;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            trap_vector <= pvic_pkg::VEC_TRAP;
        end else begin
            trap_vector <= pvic_pkg::VEC_TRAP;
        end
    end
endmodule : pvic_ctrl

// ---- verification/pvic_ctrl_props.sv ----
// Checker: port assertions for the interrupt controller
`timescale 1ns/1ps
module pvic_ctrl_props (
    // Clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // Watched inputs
    input wire logic adc_irq,
    input wire logic uart0_rx_irq,
    input wire logic gate_set,
    input wire logic gate_clear,
    input wire logic trap_req,
    input wire logic ack,
    // Watched outputs
    input wire logic global_irq_gate,
    input wire logic [24:0] pending,
    input wire pvic_pkg::pvic_req_t req,
    input wire logic [15:0] reset_vector,
    input wire logic [15:0] trap_vector
);
    default clocking @(posedge clk); endclocking
    default disable iff (!arst_n);
    sequence s_taken;
        ack && req.valid;
    endsequence
    sequence s_open;
        gate_set && !gate_clear && !ack && !trap_req;
    endsequence
    AST_RESET_VEC: assert property (reset_vector == 16'h0002)
        else $error("reset vector wrong");
    AST_TRAP_VEC: assert property (trap_vector == 16'h0006)
        else $error("trap vector wrong");
    AST_VEC_MAP: assert property (req.valid |-> req.vector == ((req.idx == 5'h00) ? 16'h0004 :
        16'h0006 + {10'h000, req.idx, 1'b0})) else $error("vector does not match source");
    AST_GATE_SHUT: assert property (!global_irq_gate [*2] |-> !req.valid)
        else $error("request shown while gate shut");
    AST_GATE_CLOSE: assert property ((ack || trap_req || gate_clear) |=> !global_irq_gate)
        else $error("gate stayed open");
    AST_GATE_OPEN: assert property (s_open |=> global_irq_gate)
        else $error("gate did not open");
    AST_ACK_DROP: assert property (s_taken |=> !req.valid)
        else $error("request stood after ack");
    AST_PULSE_SET: assert property (adc_irq |=> pending[8])
        else $error("pulse not pending");
    AST_PULSE_ACK: assert property (s_taken ##0 (req.idx == 5'h08 && !adc_irq) |=> !pending[8])
        else $error("pulse not cleared by ack");
    AST_HELD_SET: assert property (uart0_rx_irq |=> pending[4])
        else $error("held source not pending");
endmodule : pvic_ctrl_props

bind pvic_ctrl pvic_ctrl_props u_props (.clk(clk), .arst_n(arst_n), .adc_irq(adc_irq),
    .uart0_rx_irq(uart0_rx_irq), .gate_set(gate_set), .gate_clear(gate_clear), .trap_req(trap_req),
    .ack(ack), .global_irq_gate(global_irq_gate), .pending(pending), .req(req),
    .reset_vector(reset_vector), .trap_vector(trap_vector));

// ---- verification/pvic_core_model.sv ----
// Core model: takes vectored requests and acknowledges them
`timescale 1ns/1ps
module pvic_core_model (
    // Clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // Controller side
    input wire pvic_pkg::pvic_req_t req,
    input wire logic [3:0] dly,
    output logic ack,
    // Last request taken
    output pvic_pkg::pvic_req_t taken,
    output logic [7:0] n_taken
);
    logic [3:0] cnt;
    // Ack only while a request stands; slow answers via dly
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ack <= 1'b0;
            cnt <= 4'h0;
            taken <= '0;
            n_taken <= 8'h00;
        end else if (ack) begin
            ack <= 1'b0;
            cnt <= 4'h0;
            taken <= req;
            n_taken <= n_taken + 8'h01;
        end else if (req.valid) begin
            ack <= (cnt >= dly);
            cnt <= cnt + 4'h1;
        end
    end
endmodule : pvic_core_model

// ---- verification/test_pvic_ctrl.sv ----
// Testbench for the interrupt controller
`timescale 1ns/1ps
module test_pvic_ctrl;
    logic clk = 1'b0, arst_n = 1'b0, ack, gate, gate_set = 1'b0, gate_clear = 1'b0, trap_req = 1'b0;
    logic [24:0] drv = '0, enable = '1, wz = '0, pending;
    logic [49:0] level = {25{2'h2}};
    logic [7:0] d_pin = '0, sel = '0, fall = '0, n_taken, n0;
    logic [3:0] dly = 4'h0;
    logic wmode = 1'b1;
    logic [15:0] rv, tv;
    pvic_pkg::pvic_req_t req, taken;
    int fails = 0, comparisons = 0;
    // Row i: fire source bit i, expect this vector
    logic [15:0] vec_tab [25] = '{16'h0004, 16'h0008, 16'h000a, 16'h000c, 16'h000e, 16'h0010, 16'h0012,
        16'h0014, 16'h0016, 16'h0018, 16'h001a, 16'h001c, 16'h001e, 16'h0020, 16'h0022, 16'h0024,
        16'h0026, 16'h0028, 16'h002a, 16'h002c, 16'h002e, 16'h0030, 16'h0032, 16'h0034, 16'h0036};
    pvic_ctrl dut (.clk(clk), .arst_n(arst_n), .wdt_irq(drv[0]), .wdt_irq_mode(wmode),
        .tmr_irq({drv[1], drv[2], drv[3]}), .tmr3_irq(drv[17]), .uart0_rx_irq(drv[4]),
        .uart0_tx_irq(drv[5]), .uart1_rx_irq(drv[18]), .uart1_tx_irq(drv[19]), .i2c_irq(drv[6]),
        .spi_irq(drv[7]), .adc_irq(drv[8]), .dma_irq(drv[20]), .port_d_pin(d_pin),
        .port_a_pin({drv[9], drv[10], drv[11], drv[12], drv[13], drv[14], drv[15], drv[16]}),
        .port_c_pin({drv[21], drv[22], drv[23], drv[24]}), .pin_port_sel(sel), .pin_falling(fall),
        .enable(enable), .level(level), .gate_set(gate_set), .gate_clear(gate_clear),
        .pend_wr_zero(wz), .trap_req(trap_req), .ack(ack), .global_irq_gate(gate), .pending(pending),
        .req(req), .reset_vector(rv), .trap_vector(tv));
    pvic_core_model u_core (.clk(clk), .arst_n(arst_n), .req(req), .dly(dly), .ack(ack),
        .taken(taken), .n_taken(n_taken));
    initial forever #5 clk = ~clk;
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    // Open the gate and wait, bounded, for the core to take one request
    task automatic take(input int exp);
        n0 = n_taken;
        gate_set <= 1'b1;
        @(posedge clk);
        gate_set <= 1'b0;
        for (int k = 0; k < 60 && n_taken === n0; k++) @(posedge clk);
        chk("taken count", 8'(n0 + 8'h01), n_taken);
        chk("index", exp, taken.idx);
    endtask : take
    // Pins need the synchroniser delay before a zero write can clear them
    task automatic clr;
        drv <= '0;
        repeat (8) @(posedge clk);
        wz <= '1;
        @(posedge clk);
        wz <= '0;
        @(posedge clk);
    endtask : clr
    task automatic results;
        if (fails == 0 && comparisons > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : results
    initial begin
        repeat (20000) @(posedge clk);
        fails++;
        results();
    end
    initial begin
        repeat (6) @(posedge clk);
        arst_n <= 1'b1;
        @(posedge clk);
        chk("reset req", 0, req);
        chk("reset pend", 0, pending);
        chk("reset gate", 0, gate);
        chk("reset vector", 16'h0002, rv);
        chk("trap vector", 16'h0006, tv);
        for (int i = 0; i < 25; i++) begin
            dly <= i[3:0] & 4'h3;
            drv[i] <= 1'b1;
            @(posedge clk);
            drv <= drv & (pvic_pkg::CONT_MASK | 25'h1e1fe00);
            take(i);
            chk("vector", vec_tab[i], taken.vector);
            clr();
        end
        level[49:48] <= 2'h3;
        drv <= 25'h100000c;
        @(posedge clk);
        drv <= 25'h1000000;
        repeat (8) @(posedge clk);
        chk("polled", 25'h100000c, pending);
        chk("gate shut", 0, req.valid);
        take(24);
        take(2);
        take(3);
        clr();
        drv[4] <= 1'b1;
        take(4);
        chk("held ack", 1, pending[4]);
        clr();
        chk("held clear", 0, pending[4]);
        wmode <= 1'b0;
        drv[0] <= 1'b1;
        repeat (3) @(posedge clk);
        chk("wdt off", 0, pending[0]);
        wmode <= 1'b1;
        drv[0] <= 1'b0;
        @(posedge clk);
        level[17:16] <= 2'h0;
        enable[7] <= 1'b0;
        drv <= 25'h180;
        gate_set <= 1'b1;
        @(posedge clk);
        drv <= 25'h080;
        gate_set <= 1'b0;
        repeat (10) @(posedge clk);
        chk("refused", 0, req.valid);
        chk("refused pend", 2'h3, pending[8:7]);
        gate_clear <= 1'b1;
        @(posedge clk);
        gate_clear <= 1'b0;
        clr();
        sel[0] <= 1'b1;
        fall[0] <= 1'b1;
        d_pin[0] <= 1'b1;
        repeat (8) @(posedge clk);
        chk("rise ignored", 0, pending[16]);
        d_pin[0] <= 1'b0;
        repeat (8) @(posedge clk);
        take(16);
        trap_req <= 1'b1;
        gate_set <= 1'b1;
        @(posedge clk);
        trap_req <= 1'b0;
        gate_set <= 1'b0;
        drv[20] <= 1'b1;
        @(posedge clk);
        drv[20] <= 1'b0;
        chk("trap gate", 0, gate);
        @(posedge clk);
        chk("dma pend", 1, pending[20]);
        wz <= 25'h0100000;
        @(posedge clk);
        wz <= '0;
        @(posedge clk);
        chk("zero write", 0, pending[20]);
        arst_n <= 1'b0;
        @(posedge clk);
        chk("mid reset", 0, pending);
        chk("mid reset req", 0, req);
        arst_n <= 1'b1;
        @(posedge clk);
        results();
    end
endmodule : test_pvic_ctrl
